// File: core/pdio_pkg.sv
// package: register map, field positions and reset values of the digital io block
package pdio_pkg;

  // second address region offsets
  localparam logic [4:0] OFS_INPUT_LEVELS     = 5'h00;
  localparam logic [4:0] OFS_OUTPUT_LEVELS    = 5'h01;
  localparam logic [4:0] OFS_EDGE_IRQ_ENABLE  = 5'h02;
  localparam logic [4:0] OFS_EDGE_POLARITY    = 5'h03;
  localparam logic [4:0] OFS_EDGE_EVENT_FLAGS = 5'h07;
  localparam logic [4:0] OFS_BEEPER_CONTROL   = 5'h11;
  // first address region offset
  localparam logic [4:0] OFS_LOGIC_REVISION   = 5'h1f;

  // beeper field positions
  localparam int BEEPER_ON_BIT       = 0;
  localparam int BEEP_PATTERN_LO_BIT = 1;
  localparam int BEEP_PATTERN_HI_BIT = 2;

  // reset values
  localparam logic [7:0] RST_OUTPUT_LEVELS = 8'h00;
  localparam logic [1:0] RST_EDGE_ENABLE   = 2'h0;
  localparam logic [1:0] RST_EDGE_POLARITY = 2'h0;
  localparam logic [1:0] RST_EDGE_FLAGS    = 2'h0;
  localparam logic [2:0] RST_BEEPER        = 3'h0;

  // beep patterns
  typedef enum logic [1:0] {
    PDIO_BEEP_CONT   = 2'h0,
    PDIO_BEEP_SHORT  = 2'h1,
    PDIO_BEEP_MIDDLE = 2'h2,
    PDIO_BEEP_LONG   = 2'h3
  } pdio_beep_t;

  // beep timing, on and off half periods
  localparam int CLK_PERIOD_NS   = 5;
  localparam int BEEP_SHORT_MS   = 100;
  localparam int BEEP_MIDDLE_MS  = 250;
  localparam int BEEP_LONG_MS    = 500;
  localparam int BEEP_SHORT_CYC  = BEEP_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BEEP_MIDDLE_CYC = BEEP_MIDDLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BEEP_LONG_CYC   = BEEP_LONG_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// File: core/pdio_edge_chan.sv
// one edge interrupt channel: edge detect and sticky flag
`timescale 1ns/1ps
`default_nettype none
module pdio_edge_chan (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic line_in,
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic clear,
  output logic      flag
);
  import pdio_pkg::*;

  logic prev_ff;
  logic flag_ff;
  logic nxt_flag;
  logic hit;

  // previous line level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= line_in;
    end
  end

  // selected edge on an enabled line
  assign hit = enable & (polarity ? (line_in & ~prev_ff) : (~line_in & prev_ff));
  // set wins over clear
  assign nxt_flag = hit | (flag_ff & ~clear);

  // sticky flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

  a_flag_sets_on_edge: assert property (@(posedge clk) disable iff (!rst_n)
    hit |=> flag) else $error("edge not flagged");
  a_flag_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
    (clear && !hit) |=> !flag) else $error("flag not cleared");
  a_flag_holds_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (flag && !clear) |=> flag) else $error("flag lost without clear");
  a_flag_needs_cause: assert property (@(posedge clk) disable iff (!rst_n)
    (!flag && !enable) |=> !flag) else $error("flag set while disabled");

endmodule // pdio_edge_chan
`default_nettype wire

// File: core/pdio_top.sv
// register block for the pci digital io port with edge interrupts and beeper
`timescale 1ns/1ps
`default_nettype none
module pdio_top #(
  parameter int NUM_IN        = 8,
  parameter int NUM_OUT       = 8,
  parameter int NUM_EDGE      = 2,
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter int SHORT_CYC     = pdio_pkg::BEEP_SHORT_CYC,
  parameter int MIDDLE_CYC    = pdio_pkg::BEEP_MIDDLE_CYC,
  parameter int LONG_CYC      = pdio_pkg::BEEP_LONG_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               reg_sel0,
  input  wire logic               reg_sel1,
  input  wire logic [4:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic [NUM_IN-1:0]  input_lines,
  output logic      [NUM_OUT-1:0] output_lines,
  output logic                    beeper_out,
  output logic                    irq_req
);
  import pdio_pkg::*;

  logic [NUM_OUT-1:0]  out_ff;
  logic [NUM_EDGE-1:0] ena_ff;
  logic [NUM_EDGE-1:0] pol_ff;
  logic [2:0]          beep_ff;
  logic [7:0]          rdata_ff;
  logic [7:0]          nxt_rdata;
  logic [NUM_EDGE-1:0] flags;
  logic [NUM_EDGE-1:0] clr;
  logic                wr1;
  logic                wr0_unused;
  logic [31:0]         beep_cnt_ff;
  logic                tone_ff;
  logic [31:0]         half_cyc;
  logic                irq_ff;

  // write strobes of region one and of region zero
  assign wr1 = reg_sel1 & reg_wr;
  assign wr0_unused = reg_sel0 & reg_wr;

  // output lines register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= RST_OUTPUT_LEVELS[NUM_OUT-1:0];
    end else if (wr1 && reg_addr == OFS_OUTPUT_LEVELS) begin
      out_ff <= reg_wdata[NUM_OUT-1:0];
    end
  end

  // edge enable and polarity registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_ff <= RST_EDGE_ENABLE;
      pol_ff <= RST_EDGE_POLARITY;
    end else begin
      if (wr1 && reg_addr == OFS_EDGE_IRQ_ENABLE) begin
        ena_ff <= reg_wdata[NUM_EDGE-1:0];
      end
      if (wr1 && reg_addr == OFS_EDGE_POLARITY) begin
        pol_ff <= reg_wdata[NUM_EDGE-1:0];
      end
    end
  end

  // beeper control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beep_ff <= RST_BEEPER;
    end else if (wr1 && reg_addr == OFS_BEEPER_CONTROL) begin
      beep_ff <= reg_wdata[2:0];
    end
  end

  // write-one clear of the flags
  assign clr = (wr1 && reg_addr == OFS_EDGE_EVENT_FLAGS) ? reg_wdata[NUM_EDGE-1:0] : '0;

  // edge channels
  for (genvar i = 0; i < NUM_EDGE; i++) begin : g_edge
    pdio_edge_chan u_chan (
      .clk      (clk),
      .rst_n    (rst_n),
      .line_in  (input_lines[i]),
      .enable   (ena_ff[i]),
      .polarity (pol_ff[i]),
      .clear    (clr[i]),
      .flag     (flags[i])
    );
  end

  // interrupt request follows the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |flags;
    end
  end
  assign irq_req = irq_ff;

  // read mux
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_sel0) begin
      if (reg_addr == OFS_LOGIC_REVISION) begin
        nxt_rdata = REVISION;
      end
    end else if (reg_sel1) begin
      unique case (reg_addr)
        OFS_INPUT_LEVELS:     nxt_rdata = 8'(input_lines);
        OFS_OUTPUT_LEVELS:    nxt_rdata = 8'(out_ff);
        OFS_EDGE_IRQ_ENABLE:  nxt_rdata = 8'(ena_ff);
        OFS_EDGE_POLARITY:    nxt_rdata = 8'(pol_ff);
        OFS_EDGE_EVENT_FLAGS: nxt_rdata = 8'(flags);
        OFS_BEEPER_CONTROL:   nxt_rdata = {5'h00, beep_ff};
        default:              nxt_rdata = 8'h00;
      endcase
    end
  end

  // registered read data, loaded on a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;
  assign output_lines = out_ff;

  // half period of the selected pattern
  always_comb begin
    unique case (pdio_beep_t'(beep_ff[BEEP_PATTERN_HI_BIT:BEEP_PATTERN_LO_BIT]))
      PDIO_BEEP_SHORT:  half_cyc = 32'(SHORT_CYC);
      PDIO_BEEP_MIDDLE: half_cyc = 32'(MIDDLE_CYC);
      PDIO_BEEP_LONG:   half_cyc = 32'(LONG_CYC);
      default:          half_cyc = 32'h0;
    endcase
  end

  // beep gating: continuous or on/off cadence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beep_cnt_ff <= 32'h0;
      tone_ff     <= 1'b0;
    end else if (!beep_ff[BEEPER_ON_BIT]) begin
      beep_cnt_ff <= 32'h0;
      tone_ff     <= 1'b0;
    end else if (half_cyc == 32'h0) begin
      beep_cnt_ff <= 32'h0;
      tone_ff     <= 1'b1;
    end else if (beep_cnt_ff + 32'h1 >= half_cyc) begin
      beep_cnt_ff <= 32'h0;
      tone_ff     <= ~tone_ff;
    end else begin
      beep_cnt_ff <= beep_cnt_ff + 32'h1;
    end
  end
  assign beeper_out = tone_ff;

  a_out_follows_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr1 && reg_addr == OFS_OUTPUT_LEVELS) |=> output_lines == $past(reg_wdata)) else $error("outputs wrong");
  a_region0_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (wr0_unused && !wr1) |=> $stable(output_lines)) else $error("region zero write changed outputs");
  a_input_read_value: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_sel1 && !reg_sel0 && reg_addr == OFS_INPUT_LEVELS) |=> reg_rdata == $past(input_lines))
    else $error("input read wrong");
  a_enable_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (wr1 && reg_addr == OFS_EDGE_IRQ_ENABLE) |=> ena_ff == $past(reg_wdata[1:0])) else $error("enable not stored");
  a_polarity_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (wr1 && reg_addr == OFS_EDGE_POLARITY) |=> pol_ff == $past(reg_wdata[1:0])) else $error("polarity not stored");
  a_flags_read_value: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_sel1 && !reg_sel0 && reg_addr == OFS_EDGE_EVENT_FLAGS) |=> reg_rdata == 8'($past(flags)))
    else $error("flag read wrong");
  a_irq_tracks_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (|flags) |=> irq_req) else $error("irq missing");
  a_irq_drops_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (flags == '0) |=> !irq_req) else $error("irq stuck");
  a_beeper_off_silent: assert property (@(posedge clk) disable iff (!rst_n)
    !beep_ff[BEEPER_ON_BIT] |=> !beeper_out) else $error("beeper sounds while off");
  a_beep_cont_on: assert property (@(posedge clk) disable iff (!rst_n)
    (beep_ff == 3'h1) |=> beeper_out) else $error("continuous beep silent");

  c_irq_raised: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_req));
  c_irq_cleared: cover property (@(posedge clk) disable iff (!rst_n) $fell(irq_req));
  c_both_flags: cover property (@(posedge clk) disable iff (!rst_n) flags == 2'h3);
  c_beep_toggle: cover property (@(posedge clk) disable iff (!rst_n) beep_ff[0] && $fell(beeper_out));

endmodule // pdio_top
`default_nettype wire

// File: bench/pdio_host.sv
// host model: register reads and writes, changed at the falling edge
`timescale 1ns/1ps
`default_nettype none
module pdio_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_sel0,
  output logic            reg_sel1,
  output logic [4:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata
);
  // idle bus at time zero
  initial begin
    {reg_sel0, reg_sel1, reg_wr, reg_rd} = 4'h0;
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
  end
  // one access: request held over one rising edge, released at the next fall
  task automatic acc(input logic r1, input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    reg_sel0  <= !r1;
    reg_sel1  <= r1;
    reg_addr  <= a;
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_wdata <= d;
    @(negedge clk);
    q = reg_rdata;
    {reg_sel0, reg_sel1, reg_wr, reg_rd} <= 4'h0;
    reg_addr  <= ~a; // released: no stale value
    reg_wdata <= ~d;
  endtask
endmodule // pdio_host
`default_nettype wire

// File: bench/test_pci_digital_io_irq_buzzer.sv
// self-checking bench for the digital io register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_pci_digital_io_irq_buzzer;
  import pdio_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary revision value
  logic       clk         = 1'b0;
  logic       rst_n       = 1'b0;
  logic [7:0] input_lines = 8'h00;
  logic       sel0, sel1, wr, rd, beeper_out, irq_req;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, output_lines, q;
  int         errors      = 0;
  int         compares    = 0;
  int         half[4]     = '{0, 4, 8, 16};
  // 200 mhz clock
  always #2.5 clk = ~clk;
  pdio_host host_u (.clk(clk), .reg_rdata(rdata), .reg_sel0(sel0), .reg_sel1(sel1), .reg_addr(addr),
                    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  pdio_top #(.REVISION(REV), .SHORT_CYC(4), .MIDDLE_CYC(8), .LONG_CYC(16)) dut_u (
    .clk(clk), .rst_n(rst_n), .reg_sel0(sel0), .reg_sel1(sel1), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .input_lines(input_lines),
    .output_lines(output_lines), .beeper_out(beeper_out), .irq_req(irq_req));
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read-back, masks, read-only and unmapped places
  task automatic t_regs;
    host_u.acc(1, 1, OFS_OUTPUT_LEVELS, 8'h5a, q);
    `CHK("output_lines", 8'h5a, output_lines)
    host_u.acc(1, 0, OFS_OUTPUT_LEVELS, 8'h00, q);
    `CHK("output_levels", 8'h5a, q)
    host_u.acc(1, 1, OFS_EDGE_IRQ_ENABLE, 8'hfe, q);
    host_u.acc(1, 0, OFS_EDGE_IRQ_ENABLE, 8'h00, q);
    `CHK("edge_irq_enable", 8'h02, q)
    host_u.acc(1, 1, OFS_EDGE_POLARITY, 8'hfd, q);
    host_u.acc(1, 0, OFS_EDGE_POLARITY, 8'h00, q);
    `CHK("edge_polarity", 8'h01, q)
    host_u.acc(1, 1, OFS_EDGE_IRQ_ENABLE, 8'h00, q);
    @(negedge clk) input_lines = 8'hc3;
    repeat (2) @(negedge clk);
    host_u.acc(1, 0, OFS_INPUT_LEVELS, 8'h00, q);
    `CHK("input_levels", 8'hc3, q)
    host_u.acc(0, 1, OFS_OUTPUT_LEVELS, 8'hff, q);
    `CHK("output_lines region0", 8'h5a, output_lines)
    host_u.acc(0, 0, OFS_LOGIC_REVISION, 8'h00, q);
    `CHK("logic_revision", REV, q)
    host_u.acc(1, 0, 5'h05, 8'h00, q);
    `CHK("unmapped", 8'h00, q)
  endtask
  // edges in both directions, disabled channels, clearing and the request
  task automatic t_edges;
    host_u.acc(1, 1, OFS_EDGE_IRQ_ENABLE, 8'h03, q);
    @(negedge clk) input_lines = 8'hc1;
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags ch1 fall", 8'h02, q)
    @(negedge clk) input_lines = 8'hc0;
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags wrong edge", 8'h02, q)
    @(negedge clk) input_lines = 8'hc1;
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags ch0 rise", 8'h03, q)
    `CHK("irq_req set", 1'b1, irq_req)
    host_u.acc(1, 1, OFS_EDGE_EVENT_FLAGS, 8'hfc, q);
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags zero write", 8'h03, q)
    host_u.acc(1, 1, OFS_EDGE_EVENT_FLAGS, 8'h01, q);
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags clear ch0", 8'h02, q)
    `CHK("irq_req one flag", 1'b1, irq_req)
    host_u.acc(1, 1, OFS_EDGE_EVENT_FLAGS, 8'h02, q);
    repeat (2) @(negedge clk);
    `CHK("irq_req cleared", 1'b0, irq_req)
    host_u.acc(1, 1, OFS_EDGE_IRQ_ENABLE, 8'h00, q);
    @(negedge clk) input_lines = 8'hc0;
    @(negedge clk) input_lines = 8'hc1;
    host_u.acc(1, 0, OFS_EDGE_EVENT_FLAGS, 8'h00, q);
    `CHK("flags disabled", 8'h00, q)
  endtask
  // counts falling edges until the beeper gate rises
  task automatic wait_rise(output int k);
    logic b;
    b = beeper_out;
    k = 0;
    @(negedge clk);
    k++;
    while (!(beeper_out === 1'b1 && b === 1'b0) && k < 200) begin
      b = beeper_out;
      @(negedge clk);
      k++;
    end
  endtask
  // every pattern, continuous level and disable
  task automatic t_beep;
    int k;
    host_u.acc(1, 1, OFS_BEEPER_CONTROL, 8'hf9, q);
    host_u.acc(1, 0, OFS_BEEPER_CONTROL, 8'h00, q);
    `CHK("beeper_control", 8'h01, q)
    repeat (3) @(negedge clk);
    `CHK("beeper continuous", 1'b1, beeper_out)
    for (int p = 1; p < 4; p++) begin
      host_u.acc(1, 1, OFS_BEEPER_CONTROL, 8'(p * 2 + 1), q);
      wait_rise(k);
      wait_rise(k);
      `CHK("beep period", 2 * half[p], k)
    end
    host_u.acc(1, 1, OFS_BEEPER_CONTROL, 8'h06, q);
    repeat (40) @(negedge clk);
    `CHK("beeper off", 1'b0, beeper_out)
  endtask
  // reset, then the scenarios
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset outputs", 10'h000, {output_lines, beeper_out, irq_req})
    t_regs();
    t_edges();
    t_beep();
    give_verdict();
  end
  // watchdog
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule // test_pci_digital_io_irq_buzzer
`default_nettype wire
